// ---- hdl/pci_master_options_control.sv ----
// Functional notes
// - read command 0: pick read command from cache line size and count
// - read command 1/2/3 force multiple, line, plain memory read
// - all-zero priority field gives round robin, else priority arbitration
// - bits 15-14 general dma level, 13-12 core requester level
// - bits 11-10 receive queue level, 9-8 interrupt status level
// - bit 7: hurry general dma while vector status waits
// - bit 6: hurry general dma while receive queue waits
// - bit 5: hurry general dma while core requester waits
// - bit 4: all byte enables active on every read
// - bit 3 has no effect
// - bit 2: a four-byte dma goes as a 32-bit transfer
// - bit 1: swap the two words on narrow-only transfers
// - bit 0: never request 64-bit, all transfers 32-bit
// - bit 31: device timeout does not stop general dma
// - bits 30, 29, 27 mask target abort, perr, parity stops
// - option register resets to all zeros
//
// Our own choices: the plain strobed port and the register offsets.
`include "pmo_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module pci_master_options_control #(
    parameter int FIFO_W = 64,
    parameter int FIFO_D = 32
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire pmo_pkg::reg_req_t regs,
    output logic [31:0] rdata,
    // 0 general dma, 1 core, 2 receive queue, 3 interrupt status
    input wire logic [3:0] req,
    output logic [3:0] gnt,
    input wire logic vector_status_wait,
    output logic hurry_up,
    input wire logic [7:0] cache_line,
    input wire logic dma_start,
    input wire pmo_pkg::dma_req_t dma,
    output logic xfer_valid,
    output pmo_pkg::xfer_t xfer,
    input wire logic err_devto,
    input wire logic err_tabort,
    input wire logic err_perr,
    input wire logic err_parity,
    output logic dma_stop,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [FIFO_W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [FIFO_W-1:0] out_data
);
    logic [31:0] opts_r;
    logic [31:0] rdata_r;
    logic [3:0] gnt_r;
    logic [1:0] owner_r;
    logic [1:0] last_r;
    pmo_pkg::arb_state_t st_r;
    logic [1:0] pick;
    logic pick_v;
    logic [1:0] best;
    logic [1:0] lvl [4];
    logic rr;
    logic hurry_nxt;
    logic hurry_r;
    pmo_pkg::xfer_t xfer_nxt;
    pmo_pkg::xfer_t xfer_r;
    logic xfer_v_r;
    logic stop_nxt;
    logic stop_r;
    logic swap_on;
    logic [FIFO_W-1:0] push_data;
    logic [16:0] line_b;
    logic [3:0] last_cmd_r;

    //--------------------------------------------------
    // register port
    //--------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            opts_r <= `PMO_OPTS_RST;
        end else if (regs.wr && regs.addr == `PMO_OPTS_OFS) begin
            opts_r <= regs.wdata & `PMO_OPTS_WMASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_r <= 32'h0000_0000;
        end else if (regs.rd && regs.addr == `PMO_OPTS_OFS) begin
            rdata_r <= opts_r;
        end else if (regs.rd && regs.addr == `PMO_STAT_OFS) begin
            rdata_r <= 32'h0000_0000;
            rdata_r[`PMO_S_GNT] <= gnt_r;
            rdata_r[`PMO_S_OWNER] <= owner_r;
            rdata_r[`PMO_S_BUSY] <= (st_r == pmo_pkg::ARB_BUSY);
            rdata_r[`PMO_S_HURRY] <= hurry_r;
            rdata_r[`PMO_S_CMD] <= last_cmd_r;
            rdata_r[`PMO_S_FULL] <= !in_ready;
            rdata_r[`PMO_S_EMPTY] <= !out_valid;
        end else begin
            // unmapped reads and idle cycles return zero
            rdata_r <= 32'h0000_0000;
        end
    end
    assign rdata = rdata_r;

    //--------------------------------------------------
    // arbiter
    //--------------------------------------------------
    assign rr = (opts_r[`PMO_F_PRIO] == 8'h00);
    assign lvl[0] = opts_r[15:14];
    assign lvl[1] = opts_r[13:12];
    assign lvl[2] = opts_r[11:10];
    assign lvl[3] = opts_r[9:8];

    // equal levels (bad programming) fall back to lowest index
    always_comb begin
        logic [1:0] idx;
        idx = 2'h0;
        pick_v = 1'b0;
        pick = 2'h0;
        best = 2'h0;
        for (int i = 0; i < 4; i++) begin
            idx = rr ? 2'(last_r + 2'(i) + 2'h1) : 2'(i);
            if (req[idx] && (!pick_v || (!rr && lvl[idx] > best))) begin
                pick_v = 1'b1;
                pick = idx;
                best = lvl[idx];
            end
        end
    end

    // owner keeps the bus until it drops its request
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_r <= pmo_pkg::ARB_IDLE;
            gnt_r <= 4'h0;
            owner_r <= 2'h0;
            last_r <= 2'h3;
        end else begin
            case (st_r)
                pmo_pkg::ARB_IDLE: begin
                    if (pick_v) begin
                        st_r <= pmo_pkg::ARB_BUSY;
                        gnt_r <= 4'(4'h1 << pick);
                        owner_r <= pick;
                    end
                end
                pmo_pkg::ARB_BUSY: begin
                    if (!req[owner_r]) begin
                        st_r <= pmo_pkg::ARB_IDLE;
                        gnt_r <= 4'h0;
                        last_r <= owner_r;
                    end
                end
                default: begin
                    st_r <= pmo_pkg::ARB_IDLE;
                    gnt_r <= 4'h0;
                end
            endcase
        end
    end
    assign gnt = gnt_r;

    //--------------------------------------------------
    // hurry-up hint
    //--------------------------------------------------
    assign hurry_nxt =
        (opts_r[`PMO_F_HURRY_VS] && vector_status_wait) ||
        (opts_r[`PMO_F_HURRY_RQ] && req[2] && !gnt_r[2]) ||
        (opts_r[`PMO_F_HURRY_PR] && req[1] && !gnt_r[1]);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            hurry_r <= 1'b0;
        end else begin
            hurry_r <= hurry_nxt;
        end
    end
    assign hurry_up = hurry_r;

    //--------------------------------------------------
    // transfer attributes
    //--------------------------------------------------
    assign line_b = {7'h00, cache_line, 2'b00};

    always_comb begin
        xfer_nxt = '0;
        xfer_nxt.be = dma.be;
        if (!dma.rd) begin
            xfer_nxt.cmd = `PMO_CMD_MW;
        end else begin
            case (pmo_pkg::rd_sel_t'(opts_r[`PMO_F_RDCMD]))
                pmo_pkg::RDSEL_MRM: xfer_nxt.cmd = `PMO_CMD_MRM;
                pmo_pkg::RDSEL_MRL: xfer_nxt.cmd = `PMO_CMD_MRL;
                pmo_pkg::RDSEL_MR: xfer_nxt.cmd = `PMO_CMD_MR;
                default: begin
                    // unknown line size gives the safe plain read
                    if (cache_line == 8'h00) begin
                        xfer_nxt.cmd = `PMO_CMD_MR;
                    end else if ({1'b0, dma.count} >= 17'(line_b << 1)) begin
                        xfer_nxt.cmd = `PMO_CMD_MRM;
                    end else if ({1'b0, dma.count} >= line_b) begin
                        xfer_nxt.cmd = `PMO_CMD_MRL;
                    end else begin
                        xfer_nxt.cmd = `PMO_CMD_MR;
                    end
                end
            endcase
            if (opts_r[`PMO_F_RD_ALL_BE]) begin
                xfer_nxt.be = 8'hFF;
            end
        end
        xfer_nxt.req64 = !opts_r[`PMO_F_NARROW] &&
            !(opts_r[`PMO_F_FOUR_NARROW] &&
              dma.count == `PMO_FOUR_BYTES);
        xfer_nxt.swap = swap_on;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            xfer_r <= '0;
            xfer_v_r <= 1'b0;
            last_cmd_r <= 4'h0;
        end else begin
            xfer_v_r <= dma_start;
            if (dma_start) begin
                xfer_r <= xfer_nxt;
                last_cmd_r <= xfer_nxt.cmd;
            end
        end
    end
    assign xfer = xfer_r;
    assign xfer_valid = xfer_v_r;

    //--------------------------------------------------
    // error stop filter
    //--------------------------------------------------
    assign stop_nxt = (err_devto && !opts_r[`PMO_F_NO_DEVTO]) ||
        (err_tabort && !opts_r[`PMO_F_NO_TABORT]) ||
        (err_perr && !opts_r[`PMO_F_NO_PERR]) ||
        (err_parity && !opts_r[`PMO_F_NO_PARITY]);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            stop_r <= 1'b0;
        end else begin
            stop_r <= stop_nxt;
        end
    end
    assign dma_stop = stop_r;

    //--------------------------------------------------
    // data buffer
    //--------------------------------------------------
    assign swap_on = opts_r[`PMO_F_NARROW] && opts_r[`PMO_F_SWAP];
    assign push_data = swap_on ?
        {in_data[FIFO_W/2-1:0], in_data[FIFO_W-1:FIFO_W/2]} : in_data;

    pmo_fifo #(
        .W(FIFO_W),
        .D(FIFO_D)
    ) u_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data(push_data),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_data)
    );

    //--------------------------------------------------
    // checks
    //--------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    logic [1:0] rr_next;
    assign rr_next = 2'(last_r + 2'h1);

    sequence s_rd_start(logic [1:0] sel);
        dma_start && dma.rd && opts_r[`PMO_F_RDCMD] == sel;
    endsequence

    property p_rd_auto;
        s_rd_start(2'h0) and (cache_line == 8'h00)
            |=> xfer_valid && xfer.cmd == `PMO_CMD_MR;
    endproperty
    a_rd_auto: assert property (p_rd_auto)
        else $error("auto read command wrong");
    property p_rd_fixed;
        s_rd_start(2'h1) |=> xfer_valid && xfer.cmd == `PMO_CMD_MRM;
    endproperty
    a_rd_fixed: assert property (p_rd_fixed)
        else $error("forced read multiple not used");
    sequence s_all_idle_req;
        st_r == pmo_pkg::ARB_IDLE && rr && req == 4'hF;
    endsequence

    property p_rr;
        s_all_idle_req |=> gnt == 4'(4'h1 << $past(rr_next));
    endproperty
    a_rr: assert property (p_rr)
        else $error("round robin order broken");
    property p_prio_dma;
        st_r == pmo_pkg::ARB_IDLE && !rr && req[0] && lvl[0] == 2'h3
            |=> gnt[0] ##1 (gnt[0] || !$past(req[0]));
    endproperty
    a_prio_dma: assert property (p_prio_dma)
        else $error("top level dma not granted");
    property p_prio_interrupt_status_requester;
        st_r == pmo_pkg::ARB_IDLE && !rr && req[3] && lvl[3] == 2'h3
            && !(req[0] && lvl[0] == 2'h3) |=> gnt[3];
    endproperty
    a_prio_interrupt_status_requester: assert property (p_prio_interrupt_status_requester)
        else $error("top level interrupt status not granted");
    property p_hurry_vs;
        opts_r[7] && vector_status_wait |=> hurry_up;
    endproperty
    a_hurry_vs: assert property (p_hurry_vs)
        else $error("no hurry for vector status");
    property p_hurry_rq;
        opts_r[6] && req[2] && !gnt[2] |=> hurry_up;
    endproperty
    a_hurry_rq: assert property (p_hurry_rq)
        else $error("no hurry for receive queue");
    property p_hurry_off;
        !(opts_r[7] && vector_status_wait)
            && !(opts_r[6] && req[2] && !gnt[2])
            && !(opts_r[5] && req[1] && !gnt[1]) |=> !hurry_up;
    endproperty
    a_hurry_off: assert property (p_hurry_off)
        else $error("hurry held without waiter");
    property p_all_be;
        dma_start && dma.rd && opts_r[4] |=> xfer.be == 8'hFF;
    endproperty
    a_all_be: assert property (p_all_be)
        else $error("read byte enables not all active");
    property p_narrow;
        dma_start && opts_r[0] |=> xfer_valid && !xfer.req64;
    endproperty
    a_narrow: assert property (p_narrow)
        else $error("64-bit requested in narrow mode");
    property p_devto;
        err_devto && opts_r[31] && !err_tabort && !err_perr
            && !err_parity |=> !dma_stop;
    endproperty
    a_devto: assert property (p_devto)
        else $error("masked timeout stopped dma");
    property p_reserved;
        (opts_r & ~`PMO_OPTS_WMASK) == 32'h0000_0000;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved option bit set");
endmodule : pci_master_options_control
`default_nettype wire

// ---- hdl/pmo_cfg.svh ----
`ifndef PMO_CFG_SVH
`define PMO_CFG_SVH
// register byte addresses
`define PMO_OPTS_OFS 8'h8C
`define PMO_STAT_OFS 8'hA0
// option register reset value and writable bits
`define PMO_OPTS_RST 32'h0000_0000
`define PMO_OPTS_WMASK 32'hEB00_FFF7
// option register fields
`define PMO_F_NO_DEVTO 31
`define PMO_F_NO_TABORT 30
`define PMO_F_NO_PERR 29
`define PMO_F_NO_PARITY 27
`define PMO_F_RDCMD 25:24
`define PMO_F_PRIO 15:8
`define PMO_F_HURRY_VS 7
`define PMO_F_HURRY_RQ 6
`define PMO_F_HURRY_PR 5
`define PMO_F_RD_ALL_BE 4
`define PMO_F_FOUR_NARROW 2
`define PMO_F_SWAP 1
`define PMO_F_NARROW 0
// status register fields
`define PMO_S_GNT 3:0
`define PMO_S_OWNER 5:4
`define PMO_S_BUSY 6
`define PMO_S_HURRY 7
`define PMO_S_CMD 11:8
`define PMO_S_FULL 12
`define PMO_S_EMPTY 13
// pci bus commands
`define PMO_CMD_MR 4'h6
`define PMO_CMD_MW 4'h7
`define PMO_CMD_MRM 4'hC
`define PMO_CMD_MRL 4'hE
`define PMO_FOUR_BYTES 16'h0004
`endif

// ---- hdl/pmo_pkg.sv ----
package pmo_pkg;
    typedef enum logic [1:0] {
        RDSEL_AUTO, RDSEL_MRM, RDSEL_MRL, RDSEL_MR
    } rd_sel_t;
    typedef enum logic {ARB_IDLE, ARB_BUSY} arb_state_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
    typedef struct packed {
        logic rd;
        logic [15:0] count;
        logic [7:0] be;
    } dma_req_t;
    typedef struct packed {
        logic [3:0] cmd;
        logic [7:0] be;
        logic req64;
        logic swap;
    } xfer_t;
endpackage : pmo_pkg

// ---- hdl/pmo_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none
module pmo_fifo #(
    parameter int W = 64,
    parameter int D = 32
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = (cnt_r != (AW+1)'(D));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule : pmo_fifo
`default_nettype wire

// ---- bench/pci_target_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module pci_target_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic slow,
    input wire logic out_valid,
    input wire logic [63:0] out_data,
    output logic out_ready,
    output logic got,
    output logic [63:0] got_data
);
    logic v_s;
    logic [63:0] d_s;
    logic [31:0] r;
    int seed = 32'hE7EB;
    // sample mid-cycle so the handshake seen is the one at the next edge
    always @(negedge core_clk) begin
        v_s <= out_valid;
        d_s <= out_data;
    end
    // slow mode accepts on roughly half the cycles
    always @(posedge core_clk) begin
        r <= $random(seed);
        got <= !rst && v_s && out_ready;
        got_data <= d_s;
        out_ready <= !rst && !stall && (!slow || r[0]);
    end
endmodule : pci_target_model
`default_nettype wire

// ---- bench/pci_master_options_control_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "pmo_cfg.svh"
module pci_master_options_control_tb_top;
    logic core_clk, rst, vsw, hurry_up, dma_start, xfer_valid, dma_stop;
    logic in_valid, in_ready, out_valid, out_ready, stall, slow, got;
    pmo_pkg::reg_req_t regs;
    pmo_pkg::dma_req_t dma;
    pmo_pkg::xfer_t xfer;
    logic [31:0] rdata;
    logic [3:0] req, gnt, err_v;
    logic [7:0] cache_line;
    logic [63:0] in_data, out_data, got_data;
    logic [63:0] q[$];
    int seed = 32'hE7EB;
    int n_mismatch = 0;
    int checks = 0;
    int last = 3;
    int mbit[4] = '{31, 30, 29, 27};

    pci_master_options_control dut (.core_clk(core_clk), .rst(rst),
        .regs(regs), .rdata(rdata), .req(req), .gnt(gnt),
        .vector_status_wait(vsw), .hurry_up(hurry_up),
        .cache_line(cache_line), .dma_start(dma_start), .dma(dma),
        .xfer_valid(xfer_valid), .xfer(xfer), .err_devto(err_v[0]),
        .err_tabort(err_v[1]), .err_perr(err_v[2]), .err_parity(err_v[3]),
        .dma_stop(dma_stop), .in_valid(in_valid), .in_ready(in_ready),
        .in_data(in_data), .out_valid(out_valid), .out_ready(out_ready),
        .out_data(out_data));
    pci_target_model far (.core_clk(core_clk), .rst(rst), .stall(stall),
        .slow(slow), .out_valid(out_valid), .out_data(out_data),
        .out_ready(out_ready), .got(got), .got_data(got_data));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regs <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        regs.wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        regs <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        regs.rd <= 1'b0;
        #1 d = rdata;
    endtask : reg_rd

    task automatic wait_gnt(input logic nz);
        int t;
        t = 0;
        while ((gnt != 4'h0) !== nz && t < 20) begin
            @(posedge core_clk);
            #1 t++;
        end
    endtask : wait_gnt

    function automatic int pick(input logic [3:0] p, input logic [7:0] pr,
                                input int lst);
        int b;
        b = -1;
        for (int k = 1; k <= 4; k++) begin
            if (pr == 8'h00 && b < 0 && p[(lst + k) % 4]) b = (lst + k) % 4;
        end
        for (int i = 0; i < 4; i++) begin
            if (pr != 8'h00 && p[i] &&
                (b < 0 || pr[2*(3-i)+:2] > pr[2*(3-b)+:2])) b = i;
        end
        return b;
    endfunction : pick

    task automatic arb_run(input logic [7:0] pr);
        logic [3:0] p;
        int e;
        reg_wr(`PMO_OPTS_OFS, {16'h0, pr, 8'h00});
        p = 4'hF;
        @(posedge core_clk);
        req <= p;
        repeat (4) begin
            wait_gnt(1'b1);
            e = pick(p, pr, last);
            chk(gnt, 64'h1 << e);
            last = e;
            p[e] = 1'b0;
            @(posedge core_clk);
            req <= p;
            wait_gnt(1'b0);
        end
    endtask : arb_run

    function automatic pmo_pkg::xfer_t exp_xfer(input logic [31:0] o,
        input pmo_pkg::dma_req_t d, input logic [7:0] cl);
        pmo_pkg::xfer_t x;
        int lb;
        lb = cl * 4;
        x.cmd = `PMO_CMD_MR;
        if (!d.rd) x.cmd = `PMO_CMD_MW;
        else if (o[25:24] == 2'h1) x.cmd = `PMO_CMD_MRM;
        else if (o[25:24] == 2'h2) x.cmd = `PMO_CMD_MRL;
        else if (o[25:24] == 2'h0 && cl != 0 && d.count >= 2 * lb)
            x.cmd = `PMO_CMD_MRM;
        else if (o[25:24] == 2'h0 && cl != 0 && d.count >= lb)
            x.cmd = `PMO_CMD_MRL;
        x.be = (d.rd && o[4]) ? 8'hFF : d.be;
        x.req64 = !o[0] && !(o[2] && d.count == `PMO_FOUR_BYTES);
        x.swap = o[0] && o[1];
        return x;
    endfunction : exp_xfer

    // ----------------------------------------
    // clock, watchdog, drain checker
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    initial begin
        repeat (60000) @(posedge core_clk);
        n_mismatch++;
        conclude();
    end

    always @(negedge core_clk) begin
        if (got === 1'b1) begin
            if (q.size() == 0) chk(got_data, 64'h0 - 1);
            else chk(got_data, q.pop_front());
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] v, o;
        logic [7:0] cl;
        pmo_pkg::dma_req_t d;
        int n, t;
        logic r;
        rst = 1'b1;
        regs = '0;
        req = 4'h0;
        vsw = 1'b0;
        cache_line = 8'h00;
        dma_start = 1'b0;
        dma = '0;
        err_v = 4'h0;
        in_valid = 1'b0;
        in_data = 64'h0;
        stall = 1'b1;
        slow = 1'b0;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        #1 chk({in_ready, out_valid, gnt, hurry_up}, 64'h40);
        reg_rd(`PMO_OPTS_OFS, v);
        chk(v, `PMO_OPTS_RST);
        reg_rd(`PMO_STAT_OFS, v);
        chk(v[31:12], 20'h2);
        reg_wr(`PMO_OPTS_OFS, 32'hFFFF_FFFF);
        reg_rd(`PMO_OPTS_OFS, v);
        chk(v, `PMO_OPTS_WMASK);
        reg_wr(8'h10, 32'h1234_5678);
        reg_rd(8'h10, v);
        chk(v, 32'h0);
        reg_wr(`PMO_STAT_OFS, 32'hFFFF_FFFF);
        reg_rd(`PMO_STAT_OFS, v);
        chk(v[31:12], 20'h2);
        arb_run(8'h00);
        arb_run(8'h1B);
        arb_run(8'h8D);
        arb_run(8'hC6);
        // hold the bus with the dma engine so others stay waiting
        for (int i = 0; i < 8; i++) begin
            reg_wr(`PMO_OPTS_OFS, 32'(i << 5));
            @(posedge core_clk);
            req <= 4'h1;
            wait_gnt(1'b1);
            @(posedge core_clk);
            req <= 4'h7;
            vsw <= 1'b1;
            repeat (3) @(posedge core_clk);
            #1 chk(hurry_up, i != 0);
            @(posedge core_clk);
            req <= 4'h0;
            vsw <= 1'b0;
            wait_gnt(1'b0);
            repeat (2) @(posedge core_clk);
            #1 chk(hurry_up, 1'b0);
        end
        for (int i = 0; i < 48; i++) begin
            o = $random(seed) & 32'h0300_001F;
            if (i % 8 == 1) o[25:24] = 2'h0;
            reg_wr(`PMO_OPTS_OFS, o);
            d.rd = 1'($random(seed));
            d.count = (i % 3 == 0) ? 16'h0004 : 16'($random(seed)) & 16'h00FF;
            d.be = 8'($random(seed));
            cl = 8'($random(seed)) & 8'h1F;
            if (i % 8 == 1) begin
                d.rd = 1'b1;
                cl = 8'h00;
            end
            @(posedge core_clk);
            dma_start <= 1'b1;
            dma <= d;
            cache_line <= cl;
            @(posedge core_clk);
            dma_start <= 1'b0;
            #1 chk(xfer_valid, 1'b1);
            chk(xfer, exp_xfer(o, d, cl));
        end
        for (int e = 0; e < 4; e++) begin
            for (int m = 0; m < 2; m++) begin
                v = 32'h1 << mbit[e];
                reg_wr(`PMO_OPTS_OFS, m ? v : (32'hE800_0000 ^ v));
                @(posedge core_clk);
                err_v <= 4'h1 << e;
                @(posedge core_clk);
                err_v <= 4'h0;
                #1 chk(dma_stop, m == 0);
            end
        end
        // fill against a stalled far side, then drain it slowly
        reg_wr(`PMO_OPTS_OFS, 32'h0);
        @(posedge core_clk);
        in_valid <= 1'b1;
        in_data <= {$random(seed), $random(seed)};
        n = 0;
        r = 1'b1;
        while (r && n < 40) begin
            @(negedge core_clk) r = in_ready;
            @(posedge core_clk);
            if (r) begin
                q.push_back(in_data);
                n++;
                in_data <= {$random(seed), $random(seed)};
            end
        end
        in_valid <= 1'b0;
        chk(n, 32);
        reg_rd(`PMO_STAT_OFS, v);
        chk(v[13:12], 2'h1);
        @(posedge core_clk);
        stall <= 1'b0;
        slow <= 1'b1;
        t = 0;
        while (q.size() != 0 && t < 400) begin
            @(posedge core_clk);
            t++;
        end
        chk(q.size(), 0);
        // narrow-only with swap: one word goes through with halves exchanged
        reg_wr(`PMO_OPTS_OFS, 32'h3);
        @(posedge core_clk);
        in_valid <= 1'b1;
        in_data <= 64'h0123_4567_89AB_CDEF;
        q.push_back(64'h89AB_CDEF_0123_4567);
        @(posedge core_clk);
        in_valid <= 1'b0;
        repeat (20) @(posedge core_clk);
        chk(q.size(), 0);
        reg_rd(`PMO_STAT_OFS, v);
        chk(v[13:12], 2'h2);
        conclude();
    end
endmodule : pci_master_options_control_tb_top
`default_nettype wire
